// ===== inc/mmee_pkg.sv
/*
  Package for the management mode entry and exit unit: save area offsets,
  reset values, item layout and the carrier structs.
  Assumes a single core clock and a memory port that acknowledges each beat.
*/
package mmee_pkg;

  localparam logic [31:0] BASE_RESET      = 32'h0003_0000;
  localparam logic [31:0] SAVE_AREA_OFS   = 32'h0000_FE00;
  localparam logic [31:0] HANDLER_OFS     = 32'h0000_8000;
  localparam int          RELOC_BIT       = 17;
  // Revision value is arbitrary; the relocation bit is forced on top of it
  localparam logic [31:0] REVISION_VALUE  = 32'h0000_0101;
  localparam logic [4:0]  SIZE_LOG2_DEF   = 5'h10;
  localparam logic [4:0]  SIZE_LOG2_MIN   = 5'h0F;
  localparam logic [5:0]  SIZE_LOG2_MAX   = 6'h20;

  // Save area item offsets from the region base
  localparam logic [15:0] OFS_REVISION    = 16'hFEFC;
  localparam logic [15:0] OFS_BASE_IMAGE  = 16'hFF00;
  localparam logic [15:0] OFS_IO_RESTART  = 16'hFEC8;
  localparam logic [15:0] OFS_AUTO_HALT   = 16'hFEC9;
  localparam logic [15:0] OFS_CS_SEL      = 16'hFE10;
  localparam logic [15:0] OFS_IO_RIP      = 16'hFEA0;

  localparam logic [2:0]  ITEM_LAST       = 3'h5;
  localparam logic [2:0]  ITEM_FIRST_LOAD = 3'h1;

  // Beat sizes
  localparam logic [1:0]  SZ_BYTE  = 2'h0;
  localparam logic [1:0]  SZ_WORD  = 2'h1;
  localparam logic [1:0]  SZ_DWORD = 2'h2;

  typedef enum {ST_IDLE, ST_SAVE, ST_ENTER, ST_INMODE, ST_RESTORE, ST_EXIT} mmee_state_type;

  // Core state that passes through the save area
  typedef struct packed {
    logic [31:0] base_image;
    logic [15:0] cs_sel;
    logic [31:0] io_rip;
    logic [7:0]  io_restart;
    logic [7:0]  auto_halt;
  } mmee_core_type;

  // One memory beat toward the region
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mmee_mem_type;

endpackage

// ===== rtl/mmee_unit.sv
/*
  Management mode entry and exit sequencer with the region base register.
  Holds the interrupt synchroniser and edge detector, the one-deep pending
  request, the save and restore beat sequencer, the base register, the mode
  flags seen by the core and by system logic, the handler launch, the region
  span and the real-mode address former.
  Entry writes six save area items, one beat each, in a fixed order:
  revision, base image, the two restart bytes, code selector and restart
  pointer. Exit reads back the same items except the revision, and the base
  register takes the reloaded image only as the mode is left.
  The page-fault address register is never part of the image; handlers that
  need it kept must save it themselves.
  Beats are at least two cycles apart: the request rises one cycle after
  the mode flag, after the restore state is entered or after the previous beat ends, and drops the cycle after
  its acknowledge.
  Assumes system logic steers memory by O_MGMT_MODE and answers each beat
  with a one-cycle I_MEM_ACK while O_MEM.req stands; read data comes with
  that acknowledge.
  Assumes the core reports the resume instruction on I_RESUME as a one-cycle
  pulse while in mode, and supplies its state on I_CORE, which is sampled as
  each save beat is issued.
  I_MGMT_INT may come from any domain; it passes two flip-flops here and only
  its rising edge requests entry.
  The size field reaches at most a 2G region, so a 4G region cannot be
  selected through it. Software keeps the base below 4G and uses
  address-size overrides once the base lies above 1M.
*/
`timescale 1ns/1ps
module mmee_unit
  import mmee_pkg::*;
(
  input  wire logic          I_CLOCK,
  input  wire logic          I_RESET,
  input  wire logic          I_MGMT_INT,
  input  wire logic          I_RESUME,
  input  wire mmee_core_type I_CORE,
  input  wire logic [4:0]    I_REGION_SIZE_LOG2,
  input  wire logic [15:0]   I_SEG_SEL,
  input  wire logic [15:0]   I_SEG_OFS,
  input  wire logic          I_MEM_ACK,
  input  wire logic [31:0]   I_MEM_RDATA,
  output mmee_mem_type       O_MEM,
  output logic               O_MGMT_MODE,
  output logic               O_INT_DISABLE,
  output logic               O_XLATE_OFF,
  output logic               O_SIZE16,
  output logic               O_FETCH_START,
  output logic [31:0]        O_FETCH_ADDR,
  output logic [15:0]        O_CS_SEL,
  output logic [31:0]        O_CS_BASE,
  output logic [31:0]        O_REGION_BASE,
  output logic [32:0]        O_REGION_TOP,
  output logic [20:0]        O_LIN_ADDR,
  output logic               O_RESTORE_VALID,
  output mmee_core_type      O_RESTORE
);

  mmee_state_type state;
  logic           int_meta;
  logic           int_sync;
  logic           int_prev;
  logic           int_edge;
  logic           pending;
  logic [31:0]    base;
  logic [2:0]     item;
  logic [15:0]    item_ofs;
  logic [1:0]     item_size;
  logic [31:0]    item_data;
  logic           beat_done;
  logic [5:0]     size_log2;
  mmee_core_type  loaded;

  // Two-flop synchroniser for the interrupt pin, then edge detection
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      int_meta <= 1'b0;
      int_sync <= 1'b0;
      int_prev <= 1'b0;
    end else begin
      int_meta <= I_MGMT_INT;
      int_sync <= int_meta;
      int_prev <= int_sync;
    end
  end
  assign int_edge  = int_sync & ~int_prev;
  assign beat_done = O_MEM.req & I_MEM_ACK;

  // Request held while in mode; an edge taken straight from idle is not kept
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      pending <= 1'b0;
    end else if (int_edge && (state != ST_IDLE || pending)) begin
      pending <= 1'b1;
    end else if (state == ST_IDLE) begin
      pending <= 1'b0;
    end
  end

  // Save area item table; the page-fault address register has no entry
  always_comb begin
    item_ofs  = OFS_REVISION;
    item_size = SZ_DWORD;
    item_data = REVISION_VALUE;
    case (item)
      3'h0: begin
        item_data            = REVISION_VALUE;
        item_data[RELOC_BIT] = 1'b1;
      end
      3'h1: begin
        item_ofs  = OFS_BASE_IMAGE;
        item_data = base;
      end
      3'h2: begin
        item_ofs  = OFS_IO_RESTART;
        item_size = SZ_BYTE;
        item_data = {24'h000000, I_CORE.io_restart};
      end
      3'h3: begin
        item_ofs  = OFS_AUTO_HALT;
        item_size = SZ_BYTE;
        item_data = {24'h000000, I_CORE.auto_halt};
      end
      3'h4: begin
        item_ofs  = OFS_CS_SEL;
        item_size = SZ_WORD;
        item_data = {16'h0000, I_CORE.cs_sel};
      end
      3'h5: begin
        item_ofs  = OFS_IO_RIP;
        item_data = I_CORE.io_rip;
      end
      default: begin
        item_ofs  = OFS_REVISION;
      end
    endcase
  end

  // Mode sequencer: save, enter, run, restore, exit
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      state <= ST_IDLE;
      item  <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (int_edge || pending) begin
            state <= ST_SAVE;
            item  <= 3'h0;
          end
        end
        ST_SAVE: begin
          if (beat_done) begin
            if (item == ITEM_LAST) begin
              state <= ST_ENTER;
            end else begin
              item <= item + 3'h1;
            end
          end
        end
        ST_ENTER: begin
          state <= ST_INMODE;
        end
        ST_INMODE: begin
          if (I_RESUME) begin
            state <= ST_RESTORE;
            item  <= ITEM_FIRST_LOAD;
          end
        end
        ST_RESTORE: begin
          if (beat_done) begin
            if (item == ITEM_LAST) begin
              state <= ST_EXIT;
            end else begin
              item <= item + 3'h1;
            end
          end
        end
        ST_EXIT: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Memory beat: one request per item, held until acknowledged
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_MEM <= '0;
    end else if ((state == ST_SAVE || state == ST_RESTORE) && !O_MEM.req) begin
      O_MEM.req   <= 1'b1;
      O_MEM.we    <= (state == ST_SAVE);
      O_MEM.size  <= item_size;
      O_MEM.addr  <= base + {16'h0000, item_ofs};
      O_MEM.wdata <= (state == ST_SAVE) ? item_data : 32'h0000_0000;
    end else if (beat_done) begin
      O_MEM.req <= 1'b0;
    end
  end

  // Capture read data during restore
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      loaded <= '0;
    end else if (state == ST_RESTORE && beat_done) begin
      case (item)
        3'h1: loaded.base_image <= I_MEM_RDATA;
        3'h2: loaded.io_restart <= I_MEM_RDATA[7:0];
        3'h3: loaded.auto_halt  <= I_MEM_RDATA[7:0];
        3'h4: loaded.cs_sel     <= I_MEM_RDATA[15:0];
        3'h5: loaded.io_rip     <= I_MEM_RDATA;
        default: loaded.io_rip  <= loaded.io_rip;
      endcase
    end
  end

  // Region base: reset value, changed only by the reloaded image
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      base <= BASE_RESET;
    end else if (state == ST_EXIT) begin
      base <= loaded.base_image;
    end
  end

  // Mode flags seen by the core and by system logic
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_MGMT_MODE   <= 1'b0;
      O_INT_DISABLE <= 1'b0;
      O_XLATE_OFF   <= 1'b0;
      O_SIZE16      <= 1'b0;
    end else if (state == ST_IDLE && (int_edge || pending)) begin
      O_MGMT_MODE   <= 1'b1;
      O_INT_DISABLE <= 1'b1;
      O_XLATE_OFF   <= 1'b1;
      O_SIZE16      <= 1'b1;
    end else if (state == ST_EXIT) begin
      O_MGMT_MODE   <= 1'b0;
      O_INT_DISABLE <= 1'b0;
      O_XLATE_OFF   <= 1'b0;
      O_SIZE16      <= 1'b0;
    end
  end

  // Handler launch after the save completes
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_FETCH_START <= 1'b0;
      O_FETCH_ADDR  <= BASE_RESET + HANDLER_OFS;
      O_CS_SEL      <= BASE_RESET[19:4];
      O_CS_BASE     <= BASE_RESET;
    end else begin
      O_FETCH_START <= (state == ST_ENTER);
      if (state == ST_ENTER) begin
        O_FETCH_ADDR <= base + HANDLER_OFS;
        O_CS_SEL     <= base[19:4];
        O_CS_BASE    <= {12'h000, base[19:4], 4'h0};
      end
    end
  end

  // Restored state handed back to the core; the restart bytes pass as they are
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_RESTORE_VALID <= 1'b0;
      O_RESTORE       <= '0;
    end else begin
      O_RESTORE_VALID <= (state == ST_EXIT);
      if (state == ST_EXIT) begin
        O_RESTORE <= loaded;
      end
    end
  end

  // Region span: size from 32K to 2G, zero selects the 64K default
  always_comb begin
    if (I_REGION_SIZE_LOG2 == 5'h00) begin
      size_log2 = {1'b0, SIZE_LOG2_DEF};
    end else if (I_REGION_SIZE_LOG2 < SIZE_LOG2_MIN) begin
      size_log2 = {1'b0, SIZE_LOG2_MIN};
    end else begin
      size_log2 = {1'b0, I_REGION_SIZE_LOG2};
    end
  end

  // Region bounds and real-mode address formation
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_REGION_BASE <= BASE_RESET;
      O_REGION_TOP  <= {1'b0, BASE_RESET} + 33'h0_0000_FFFF;
      O_LIN_ADDR    <= 21'h000000;
    end else begin
      O_REGION_BASE <= base;
      O_REGION_TOP  <= {1'b0, base} + ((33'h1 << size_log2) - 33'h1);
      O_LIN_ADDR    <= {1'b0, I_SEG_SEL, 4'h0} + {5'h00, I_SEG_OFS};
    end
  end

endmodule

// ===== tb/mmee_mem_model.sv
/* Region memory behind system logic that steers beats by the mode signal.
   Assumes req is held until a one-cycle ack. */
`timescale 1ns/1ps
module mmee_mem_model
  import mmee_pkg::*;
(
  input  wire logic         i_clock,
  input  wire logic         i_mode,
  input  wire logic         i_slow,
  input  wire mmee_mem_type i_mem,
  output logic              o_ack,
  output logic [31:0]       o_rdata
);
  logic [7:0] mem [logic [31:0]] = '{default: 8'hA5};
  int         n_writes = 0;
  int         waited = 0;
  initial o_ack = 1'b0;
  initial o_rdata = 32'h0000_0000;
  // Answers beats only while steered to the region; slow mode stalls 3 cycles
  always @(posedge i_clock) begin
    if (i_mem.req && i_mode && !o_ack && waited >= (i_slow ? 3 : 0)) begin
      waited <= 0;
      o_ack <= 1'b1;
      if (i_mem.we) n_writes <= n_writes + 1;
      if (i_mem.we) o_rdata <= ~o_rdata;
      else o_rdata <= {mem[i_mem.addr + 3], mem[i_mem.addr + 2],
                       mem[i_mem.addr + 1], mem[i_mem.addr]};
      for (int b = 0; b < 4; b++)
        if (i_mem.we && b < (1 << i_mem.size)) mem[i_mem.addr + b] = i_mem.wdata[8*b +: 8];
    end else begin
      waited <= (i_mem.req && i_mode && !o_ack) ? waited + 1 : 0;
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata; // Released data never keeps its last value
    end
  end
endmodule

// ===== tb/mmee_unit_sva.sv
/* Port checker for mmee_unit.
   Assumes a bind to the unit, one clock and a sync reset. */
`timescale 1ns/1ps
module mmee_unit_sva
  import mmee_pkg::*;
(
  input wire logic          I_CLOCK,
  input wire logic          I_RESET,
  input wire logic [15:0]   I_SEG_SEL,
  input wire logic [15:0]   I_SEG_OFS,
  input wire logic          I_MEM_ACK,
  input wire mmee_mem_type  O_MEM,
  input wire logic          O_MGMT_MODE,
  input wire logic          O_INT_DISABLE,
  input wire logic          O_XLATE_OFF,
  input wire logic          O_SIZE16,
  input wire logic          O_FETCH_START,
  input wire logic [31:0]   O_FETCH_ADDR,
  input wire logic [15:0]   O_CS_SEL,
  input wire logic [31:0]   O_REGION_BASE,
  input wire logic [20:0]   O_LIN_ADDR,
  input wire logic          O_RESTORE_VALID,
  input wire mmee_core_type O_RESTORE
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  // Offset of the current beat from the region base
  logic [31:0] ofs;
  assign ofs = O_MEM.addr - O_REGION_BASE;
  sequence s_rev_beat;
    O_MEM.req && O_MEM.we && ofs == 32'h0000_FEFC && O_MEM.wdata[RELOC_BIT];
  endsequence
  sequence s_base_load;
    O_RESTORE_VALID ##1 O_REGION_BASE == $past(O_RESTORE.base_image);
  endsequence
  AST_ENTRY: assert property ($rose(O_MGMT_MODE) |=> s_rev_beat)
    else $error("bad entry beat");
  AST_EXIT: assert property ($fell(O_MGMT_MODE) |-> s_base_load)
    else $error("bad exit");
  AST_HOLD: assert property (O_MEM.req && !I_MEM_ACK |=> $stable(O_MEM))
    else $error("beat changed");
  AST_AREA: assert property (O_MEM.req |-> ofs >= SAVE_AREA_OFS && ofs <= 32'h0000_FFFF)
    else $error("beat outside save area");
  AST_BYTES: assert property (O_MEM.req && ofs[31:1] == 31'h7F64 |-> O_MEM.size == SZ_BYTE)
    else $error("restart item not a byte");
  AST_MASK: assert property (O_INT_DISABLE == O_MGMT_MODE)
    else $error("mask differs from mode");
  AST_REAL: assert property (O_XLATE_OFF == O_MGMT_MODE && O_SIZE16 == O_MGMT_MODE)
    else $error("addressing flags differ from mode");
  AST_LIN: assert property (!$past(I_RESET) |->
    O_LIN_ADDR == {1'b0, $past(I_SEG_SEL), 4'h0} + 21'($past(I_SEG_OFS)))
    else $error("bad linear address");
  AST_HANDLER: assert property (O_FETCH_START |->
    O_FETCH_ADDR == O_REGION_BASE + HANDLER_OFS && O_CS_SEL == O_REGION_BASE[19:4])
    else $error("bad handler start");
  AST_BASE: assert property ($changed(O_REGION_BASE) |-> $past(O_RESTORE_VALID))
    else $error("base changed outside exit");
endmodule

// ===== tb/mmee_unit_test.sv
/* Self-checking bench for mmee_unit with the region memory model.
   Assumes a 200 MHz clock; inputs change on the falling edge. */
`timescale 1ns/1ps
module mmee_unit_test;
  import mmee_pkg::*;
  logic          clock = 1'b0, reset = 1'b1, mint = 1'b0, resume = 1'b0, slow = 1'b0;
  logic [4:0]    size_log2 = 5'h00;
  logic [15:0]   sel = 16'h0000, ofs = 16'h0000, cs_sel;
  mmee_core_type core = {32'h0, 16'h1234, 32'h0000_5678, 8'hFF, 8'h01};
  logic          ack, mode, intoff, xoff, s16, fstart, rvalid;
  logic [31:0]   rdata, faddr, base, csbase;
  logic [32:0]   top;
  logic [20:0]   lin;
  mmee_mem_type  mem;
  mmee_core_type rest;
  int            failures = 0, n_checks = 0;
  mmee_unit dut (.I_CLOCK(clock), .I_RESET(reset), .I_MGMT_INT(mint), .I_RESUME(resume),
    .I_CORE(core), .I_REGION_SIZE_LOG2(size_log2), .I_SEG_SEL(sel), .I_SEG_OFS(ofs),
    .I_MEM_ACK(ack), .I_MEM_RDATA(rdata), .O_MEM(mem), .O_MGMT_MODE(mode),
    .O_INT_DISABLE(intoff), .O_XLATE_OFF(xoff), .O_SIZE16(s16), .O_FETCH_START(fstart),
    .O_FETCH_ADDR(faddr), .O_CS_SEL(cs_sel), .O_CS_BASE(csbase), .O_REGION_BASE(base),
    .O_REGION_TOP(top), .O_LIN_ADDR(lin), .O_RESTORE_VALID(rvalid), .O_RESTORE(rest));
  mmee_mem_model model (.i_clock(clock), .i_mode(mode), .i_slow(slow), .i_mem(mem),
    .o_ack(ack), .o_rdata(rdata));
  initial begin
    forever #2.5 clock = ~clock;
  end
  // Compare one value and count it
  task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // Wait for a flag on falling edges, bounded
  task automatic wait_flag(ref logic flag);
    for (int n = 0; n < 300 && flag !== 1'b1; n++) @(negedge clock);
  endtask
  // Raise the interrupt, then judge the saved image and the handler start
  task automatic do_entry(input logic [31:0] b);
    int w0;
    w0 = model.n_writes;
    @(negedge clock) mint = 1'b1;
    wait_flag(fstart);
    mint = 1'b0;
    chk("fstart", 1, fstart);
    chk("fetch", b + 32'h8000, faddr);
    chk("cs_sel", b[19:4], cs_sel);
    chk("cs_base", {12'h000, b[19:4], 4'h0}, csbase);
    chk("mask", 1, intoff);
    chk("real", 2'b11, {xoff, s16});
    chk("rev17", 1, model.mem[b + 32'hFEFE][1]);
    chk("restart", 16'h01FF, {model.mem[b + 32'hFEC9], model.mem[b + 32'hFEC8]});
    chk("cs_img", 16'h1234, {model.mem[b + 32'hFE11], model.mem[b + 32'hFE10]});
    chk("beats", 6, model.n_writes - w0);
  endtask
  // Edit the base image, resume, and judge the reload
  task automatic do_resume(input logic [31:0] b, input logic [31:0] nb);
    for (int i = 0; i < 4; i++) model.mem[b + 32'hFF00 + i] = nb[8*i +: 8];
    @(negedge clock) resume = 1'b1;
    @(negedge clock) resume = 1'b0;
    wait_flag(rvalid);
    chk("rvalid", 1, rvalid);
    chk("rip", 32'h5678, rest.io_rip);
    chk("cs_rd", 16'h1234, rest.cs_sel);
    chk("mode", 0, mode);
    @(negedge clock);
    chk("base", nb, base);
  endtask
  task print_verdict;
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    chk("base", 32'h3_0000, base);
    chk("cs_sel", 16'h3000, cs_sel);
    chk("top", 33'h3_FFFF, top);
    sel = 16'hFFFF;
    ofs = 16'hFFFF;
    repeat (2) @(negedge clock);
    chk("lin", 21'h10_FFEF, lin);
    do_entry(32'h3_0000);
    slow = 1'b1;
    do_resume(32'h3_0000, 32'h5_0000);
    do_entry(32'h5_0000);
    @(negedge clock) mint = 1'b1;
    repeat (3) @(negedge clock);
    mint = 1'b0;
    chk("held", 1, mode);
    do_resume(32'h5_0000, 32'h5_0000);
    wait_flag(fstart);
    chk("pending", 1, fstart);
    do_resume(32'h5_0000, 32'h5_0000);
    size_log2 = 5'h0F;
    repeat (3) @(negedge clock);
    chk("idle", 0, mode);
    chk("top32k", 33'h5_7FFF, top);
    print_verdict;
  end
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100us;
    failures++;
    print_verdict;
  end
endmodule
bind mmee_unit mmee_unit_sva sva (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
  .I_SEG_SEL(I_SEG_SEL), .I_SEG_OFS(I_SEG_OFS), .I_MEM_ACK(I_MEM_ACK), .O_MEM(O_MEM),
  .O_MGMT_MODE(O_MGMT_MODE), .O_INT_DISABLE(O_INT_DISABLE), .O_XLATE_OFF(O_XLATE_OFF),
  .O_SIZE16(O_SIZE16), .O_FETCH_START(O_FETCH_START), .O_FETCH_ADDR(O_FETCH_ADDR),
  .O_CS_SEL(O_CS_SEL), .O_REGION_BASE(O_REGION_BASE), .O_LIN_ADDR(O_LIN_ADDR),
  .O_RESTORE_VALID(O_RESTORE_VALID), .O_RESTORE(O_RESTORE));
